//--- pkg/mps_pkg.sv
`default_nettype none
package mps_pkg;
   // ************************************************************
   // timing counts at 25 MHz
   // ************************************************************
   localparam int unsigned CLK_HZ          = 25000000;
   localparam int unsigned MOD_RAMP_US     = 100;   // own power ramp time
   localparam int unsigned MOD_RAMP_CYC    = (MOD_RAMP_US * (CLK_HZ / 1000000));
   localparam int unsigned CAR_RAMP_US     = 100;   // carrier power ramp time
   localparam int unsigned CAR_RAMP_CYC    = (CAR_RAMP_US * (CLK_HZ / 1000000));
   localparam int unsigned RST_HOLD_US     = 20;    // processor reset lead before power drop
   localparam int unsigned RST_HOLD_CYC    = (RST_HOLD_US * (CLK_HZ / 1000000));
   localparam int unsigned CNT_W           = 12;
   localparam int unsigned SYNC_STAGES     = 2;
   localparam int unsigned PWM_W           = 8;
   localparam int unsigned PWM_DIV_W       = 8;
   localparam int unsigned PWM_MAX_HZ      = 102000000;
   localparam int unsigned N_SYNC          = 7;
   // bit positions inside the synchronised input vector
   localparam int unsigned IN_PBAD         = 0;
   localparam int unsigned IN_BTN          = 1;
   localparam int unsigned IN_SLEEP        = 2;
   localparam int unsigned IN_CHG          = 3;
   localparam int unsigned IN_SYSRST       = 4;
   localparam int unsigned IN_CPURST       = 5;
   localparam int unsigned IN_PRIRST       = 6;
   localparam logic [N_SYNC-1:0] SYNC_RST  = 7'h7F; // all inactive high

   typedef enum logic [2:0] {
      MPS_OFF      = 3'b000,
      MPS_MOD_UP   = 3'b001,
      MPS_CAR_UP   = 3'b010,
      MPS_ON       = 3'b011,
      MPS_SLEEP    = 3'b100,
      MPS_RST_DN   = 3'b101,
      MPS_CAR_DN   = 3'b110,
      MPS_MOD_DN   = 3'b111
   } mps_state_e;

   typedef struct packed {
      logic pmgr_rst_n;
      logic rtc_rst_n;
      logic crst_rst_n;
      logic blocks_rst_n;
   } mps_resets_s;

   typedef struct packed {
      logic sdio;
      logic i2c;
      logic spi;
      logic rtc;
      logic timer;
   } mps_wake_s;
endpackage
`default_nettype wire

//--- rtl/mps_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mps_sync (
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   input  wire logic [mps_pkg::N_SYNC-1:0] async_in,
   output logic      [mps_pkg::N_SYNC-1:0] sync_out
);
   // ************************************************************
   // two-stage synchroniser per input
   // ************************************************************
   genvar i;
   generate
      for (i = 0; i < mps_pkg::N_SYNC; i++) begin : g_sync
         logic meta_q;
         logic stab_q;
         // first stage feeds only the second stage
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               meta_q <= mps_pkg::SYNC_RST[i];
               stab_q <= mps_pkg::SYNC_RST[i];
            end else begin
               meta_q <= async_in[i];   // [R20]
               stab_q <= meta_q;        // [R20]
            end
         end
         assign sync_out[i] = stab_q;
      end
   endgenerate
endmodule
`default_nettype wire

//--- rtl/mps_pwm.sv
`timescale 1ns/1ps
`default_nettype none
module mps_pwm (
   input  wire logic                          core_clk,
   input  wire logic                          rst_n,
   input  wire logic                          enable,
   input  wire logic [mps_pkg::PWM_DIV_W-1:0] divider,
   input  wire logic [mps_pkg::PWM_W-1:0]     duty,
   output logic                               pwm_out
);
   // ************************************************************
   // divider tick and n/256 pulse generator
   // ************************************************************
   logic [mps_pkg::PWM_DIV_W-1:0] div_q;
   logic [mps_pkg::PWM_W-1:0]     phase_q;
   logic                          tick;

   // one-cycle enable every divider+1 cycles; output stays far below the ceiling
   assign tick = (div_q == divider);

   // frequency divider
   always_ff @(posedge core_clk) begin
      if (!rst_n || !enable || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;   // [R13]
      end
   end

   // phase counter, 256 steps per period
   always_ff @(posedge core_clk) begin
      if (!rst_n || !enable) begin
         phase_q <= '0;
      end else if (tick) begin
         phase_q <= phase_q + 1'b1;   // [R13]
      end
   end

   // high for duty of 256 steps
   always_ff @(posedge core_clk) begin
      if (!rst_n || !enable) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= (phase_q < duty);   // [R13]
      end
   end
endmodule
`default_nettype wire

//--- rtl/mps_top.sv
// Function
// [R01] module finishes its own power ramp before carrier power is allowed
// [R02] carrier power enable rises only after own ramp completes
// [R03] carrier holds power-bad low until input power is stable
// [R04] no power-up starts while input power-bad reads low
// [R05] primary chip reset yields controller, rtc and clock-reset unit resets
// [R06] clock-reset unit reset drives the reset of other blocks
// [R07] system reset pin is driven by module and may be pulled low by carrier
// [R08] processor reset driven by module; carrier pull resets processor only
// [R09] power button starts system power-on
// [R10] sleep request input is active low, inactive when undriven
// [R11] standby indication low in standby state, high otherwise
// [R12] enabled charger presence powers on without button press
// [R13] pwm has divider and n/256 pulse generator, max 102 MHz
// [R14] wake sources bring controller out of deep sleep
// [R15] rtc logic stays alive and detects events in low power
// [R16] during sleep hold domain states and request external power; ext_power_req rises only for one cycle after a wake event in sleep
// [R17] processor reset released after carrier powered up
// [R18] shutdown: assert processor reset, drop carrier enable, then own power
// [R19] power-on is button low-to-high while power-bad reads high
// [R20] all sideband inputs pass two flip-flops before use
`timescale 1ns/1ps
`default_nettype none
module mps_top (
   input  wire logic                          core_clk,
   input  wire logic                          rst_n,
   input  wire logic                          input_power_bad_n,
   input  wire logic                          power_button_n,
   input  wire logic                          sleep_request_n,
   input  wire logic                          charger_present_n,
   input  wire logic                          charger_autoon_en,
   input  wire logic                          primary_chip_reset_n,
   input  wire logic                          sys_reset_in_n,
   output logic                               sys_reset_out_n,
   output logic                               sys_reset_oe,
   input  wire logic                          cpu_reset_in_n,
   output logic                               cpu_reset_out_n,
   output logic                               cpu_reset_oe,
   input  wire logic                          shutdown_req,
   input  wire logic                          sleep_enter_req,
   input  wire mps_pkg::mps_wake_s            wake_events,
   output logic                               module_power_en,
   output logic                               carrier_power_enable,
   output logic                               standby_indication_n,
   output logic                               ext_power_req,
   output logic                               domain_hold,
   output mps_pkg::mps_resets_s               resets,
   output logic                               rtc_wake,
   input  wire logic                          pwm_enable,
   input  wire logic [mps_pkg::PWM_DIV_W-1:0] pwm_divider,
   input  wire logic [mps_pkg::PWM_W-1:0]     pwm_duty,
   output logic                               fan_pwm,
   output mps_pkg::mps_state_e                state
);
   // ************************************************************
   // input synchronisation
   // ************************************************************
   logic [mps_pkg::N_SYNC-1:0] raw_in;
   logic [mps_pkg::N_SYNC-1:0] sin;

   // pack pins in package bit order
   always_comb begin
      raw_in                      = '1;
      raw_in[mps_pkg::IN_PBAD]    = input_power_bad_n;
      raw_in[mps_pkg::IN_BTN]     = power_button_n;
      raw_in[mps_pkg::IN_SLEEP]   = sleep_request_n;   // pulled up off-chip  [R10]
      raw_in[mps_pkg::IN_CHG]     = charger_present_n;
      raw_in[mps_pkg::IN_SYSRST]  = sys_reset_in_n;
      raw_in[mps_pkg::IN_CPURST]  = cpu_reset_in_n;
      raw_in[mps_pkg::IN_PRIRST]  = primary_chip_reset_n;
   end

   mps_sync u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in (raw_in),
      .sync_out (sin)
   );

   logic pbad_ok;
   logic btn_s;
   logic sleep_s;
   logic chg_s;
   logic sysrst_s;
   logic cpurst_s;
   logic prirst_s;
   assign pbad_ok  = sin[mps_pkg::IN_PBAD];   // high means input stable  [R03]
   assign btn_s    = sin[mps_pkg::IN_BTN];
   assign sleep_s  = sin[mps_pkg::IN_SLEEP];
   assign chg_s    = sin[mps_pkg::IN_CHG];
   assign sysrst_s = sin[mps_pkg::IN_SYSRST];
   assign cpurst_s = sin[mps_pkg::IN_CPURST];
   assign prirst_s = sin[mps_pkg::IN_PRIRST];

   // ************************************************************
   // event detection
   // ************************************************************
   logic btn_prev_q;
   logic btn_rise;
   logic chg_on;
   logic on_event;
   logic wake_any;
   logic sys_reset_req;

   // button history for edge detect
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         btn_prev_q <= 1'b1;
      end else begin
         btn_prev_q <= btn_s;
      end
   end

   assign btn_rise      = btn_s && !btn_prev_q;              // [R19]
   assign chg_on        = charger_autoon_en && !chg_s;       // [R12]
   assign on_event      = pbad_ok && (btn_rise || chg_on);   // [R04] [R09] [R19]
   assign wake_any      = (|wake_events) || !sleep_s;         // [R14]
   assign sys_reset_req = !sysrst_s;                          // [R07]

   // ************************************************************
   // sequencing state machine
   // ************************************************************
   mps_pkg::mps_state_e      st_q;
   mps_pkg::mps_state_e      st_d;
   logic [mps_pkg::CNT_W-1:0] cnt_q;
   logic                      cnt_done;
   logic                      entering;

   assign state = st_q;

   // next-state selection
   always_comb begin
      st_d = st_q;
      case (st_q)
         mps_pkg::MPS_OFF: begin
            if (on_event) begin
               st_d = mps_pkg::MPS_MOD_UP;
            end
         end
         mps_pkg::MPS_MOD_UP: begin
            if (!pbad_ok) begin
               st_d = mps_pkg::MPS_OFF;
            end else if (cnt_done) begin
               st_d = mps_pkg::MPS_CAR_UP;   // [R01]
            end
         end
         mps_pkg::MPS_CAR_UP: begin
            if (cnt_done) begin
               st_d = mps_pkg::MPS_ON;       // [R17]
            end
         end
         mps_pkg::MPS_ON: begin
            if (shutdown_req || sys_reset_req) begin
               st_d = mps_pkg::MPS_RST_DN;   // [R18]
            end else if (sleep_enter_req) begin
               st_d = mps_pkg::MPS_SLEEP;
            end
         end
         mps_pkg::MPS_SLEEP: begin
            if (sys_reset_req) begin
               st_d = mps_pkg::MPS_RST_DN;
            end else if (wake_any) begin
               st_d = mps_pkg::MPS_ON;       // [R14]
            end
         end
         mps_pkg::MPS_RST_DN: begin
            if (cnt_done) begin
               st_d = mps_pkg::MPS_CAR_DN;   // [R18]
            end
         end
         mps_pkg::MPS_CAR_DN: begin
            if (cnt_done) begin
               st_d = mps_pkg::MPS_MOD_DN;   // [R18]
            end
         end
         mps_pkg::MPS_MOD_DN: begin
            st_d = mps_pkg::MPS_OFF;
         end
         default: begin
            st_d = mps_pkg::MPS_OFF;
         end
      endcase
   end

   assign entering = (st_d != st_q);

   // state register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_q <= mps_pkg::MPS_OFF;
      end else begin
         st_q <= st_d;
      end
   end

   // phase timer reloaded on every state change
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (entering) begin
         case (st_d)
            mps_pkg::MPS_MOD_UP: cnt_q <= mps_pkg::CNT_W'(mps_pkg::MOD_RAMP_CYC - 1);
            mps_pkg::MPS_CAR_UP: cnt_q <= mps_pkg::CNT_W'(mps_pkg::CAR_RAMP_CYC - 1);
            mps_pkg::MPS_RST_DN: cnt_q <= mps_pkg::CNT_W'(mps_pkg::RST_HOLD_CYC - 1);
            mps_pkg::MPS_CAR_DN: cnt_q <= mps_pkg::CNT_W'(mps_pkg::CAR_RAMP_CYC - 1);
            default:             cnt_q <= '0;
         endcase
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign cnt_done = (cnt_q == '0);

   // ************************************************************
   // power and standby outputs
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         module_power_en      <= 1'b0;
         carrier_power_enable <= 1'b0;
         standby_indication_n <= 1'b1;
         ext_power_req        <= 1'b0;
         domain_hold          <= 1'b0;
      end else begin
         module_power_en      <= (st_d != mps_pkg::MPS_OFF) && (st_d != mps_pkg::MPS_MOD_DN);
         carrier_power_enable <= (st_d == mps_pkg::MPS_CAR_UP) || (st_d == mps_pkg::MPS_ON) ||
                                 (st_d == mps_pkg::MPS_SLEEP) ||
                                 (st_d == mps_pkg::MPS_RST_DN);          // [R02] [R18]
         standby_indication_n <= (st_d != mps_pkg::MPS_SLEEP);           // [R11]
         ext_power_req        <= (st_q == mps_pkg::MPS_SLEEP) && wake_any; // [R16]
         domain_hold          <= (st_d == mps_pkg::MPS_SLEEP);           // [R16]
      end
   end

   // ************************************************************
   // reset distribution and reset pins
   // ************************************************************
   logic cpu_run;
   assign cpu_run = (st_q == mps_pkg::MPS_ON) || (st_q == mps_pkg::MPS_SLEEP);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         resets          <= '0;
         rtc_wake        <= 1'b0;
         cpu_reset_out_n <= 1'b0;
         cpu_reset_oe    <= 1'b1;
         sys_reset_out_n <= 1'b0;
         sys_reset_oe    <= 1'b1;
      end else begin
         resets.pmgr_rst_n   <= prirst_s;                          // [R05]
         resets.rtc_rst_n    <= prirst_s;                          // [R05] [R15]
         resets.crst_rst_n   <= prirst_s && cpu_run;               // [R05]
         resets.blocks_rst_n <= resets.crst_rst_n && cpurst_s;     // [R06] [R08]
         rtc_wake            <= (wake_events.rtc || wake_events.timer) && resets.pmgr_rst_n; // [R15]
         cpu_reset_out_n     <= cpu_run;                           // [R17] [R18]
         cpu_reset_oe        <= !cpu_run;                          // open drain, low only  [R08]
         sys_reset_out_n     <= module_power_en;                   // [R07]
         sys_reset_oe        <= !module_power_en;                  // [R07]
      end
   end

   // ************************************************************
   // fan pwm
   // ************************************************************
   mps_pwm u_pwm (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .enable   (pwm_enable),
      .divider  (pwm_divider),
      .duty     (pwm_duty),
      .pwm_out  (fan_pwm)
   );

   // ************************************************************
   // assertions
   // ************************************************************
   sequence s_shut_start;
      (st_q != mps_pkg::MPS_RST_DN) && (st_d == mps_pkg::MPS_RST_DN);
   endsequence

   sequence s_cpu_reset_held;
      !cpu_reset_out_n && carrier_power_enable;
   endsequence

   property p_car_after_mod;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(carrier_power_enable) |-> $past(st_q) == mps_pkg::MPS_MOD_UP;
   endproperty
   a_car_after_mod: assert property (p_car_after_mod) // [R01]
      else $error("carrier enable rose outside module ramp end");

   property p_car_needs_power;
      @(posedge core_clk) disable iff (!rst_n)
      carrier_power_enable |-> module_power_en;
   endproperty
   a_car_needs_power: assert property (p_car_needs_power) // [R02]
      else $error("carrier enabled without module power");

   property p_pbad_blocks;
      @(posedge core_clk) disable iff (!rst_n)
      (st_q == mps_pkg::MPS_OFF) && !pbad_ok |=> st_q == mps_pkg::MPS_OFF;
   endproperty
   a_pbad_blocks: assert property (p_pbad_blocks) // [R04]
      else $error("power-up started with input power bad");

   property p_btn_start;
      @(posedge core_clk) disable iff (!rst_n)
      (st_q == mps_pkg::MPS_OFF) && pbad_ok && btn_rise |=> st_q == mps_pkg::MPS_MOD_UP;
   endproperty
   a_btn_start: assert property (p_btn_start) // [R09]
      else $error("button release did not start power-up");

   property p_standby;
      @(posedge core_clk) disable iff (!rst_n)
      (st_q == mps_pkg::MPS_SLEEP) |-> !standby_indication_n;
   endproperty
   a_standby: assert property (p_standby) // [R11]
      else $error("standby indication high in sleep");

   property p_shutdown_order;
      @(posedge core_clk) disable iff (!rst_n)
      s_shut_start |=> ##1 s_cpu_reset_held [*8];
   endproperty
   a_shutdown_order: assert property (p_shutdown_order) // [R18]
      else $error("carrier enable dropped before processor reset");

   property p_cpu_release;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(cpu_reset_out_n) |-> carrier_power_enable && $past(carrier_power_enable, 2);
   endproperty
   a_cpu_release: assert property (p_cpu_release) // [R17]
      else $error("processor reset released before carrier up");

   property p_wake;
      @(posedge core_clk) disable iff (!rst_n)
      (st_q == mps_pkg::MPS_SLEEP) && wake_any && !sys_reset_req |=> st_q == mps_pkg::MPS_ON;
   endproperty
   a_wake: assert property (p_wake) // [R14]
      else $error("wake event did not leave sleep");

   property p_clk_rst;
      @(posedge core_clk) disable iff (!rst_n)
      !prirst_s |=> !resets.crst_rst_n ##1 !resets.blocks_rst_n;
   endproperty
   a_clk_rst: assert property (p_clk_rst) // [R05] [R06]
      else $error("primary reset did not reach derived resets");
endmodule
`default_nettype wire

//--- verification/mps_carrier_model.sv
`timescale 1ns/1ps
`default_nettype none
module mps_carrier_model #(
   parameter int SETTLE = 20
) (
   input  wire logic core_clk,
   input  wire logic vin_ok,
   input  wire logic sys_pull_n,
   input  wire logic cpu_pull_n,
   input  wire logic sys_reset_out_n,
   input  wire logic sys_reset_oe,
   input  wire logic cpu_reset_out_n,
   input  wire logic cpu_reset_oe,
   output logic      input_power_bad_n,
   output logic      sys_reset_in_n,
   output logic      cpu_reset_in_n
);
   int stable_cnt = 0;
   // ************************************************************
   // input supply monitor
   // ************************************************************
   // power-bad stays low until the input has settled for a while
   always @(posedge core_clk) begin
      if (!vin_ok) begin
         stable_cnt <= 0;
      end else if (stable_cnt < SETTLE) begin
         stable_cnt <= stable_cnt + 1;
      end
   end
   assign input_power_bad_n = (stable_cnt >= SETTLE);
   // pulled-up reset wires, low when any party drives low
   assign sys_reset_in_n = sys_pull_n & ~(sys_reset_oe & ~sys_reset_out_n);
   assign cpu_reset_in_n = cpu_pull_n & ~(cpu_reset_oe & ~cpu_reset_out_n);
endmodule
`default_nettype wire

//--- verification/module_power_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module module_power_sequencer_tb_top;
   logic                 core_clk = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 vin_ok = 1'b0, sys_pull_n = 1'b1, cpu_pull_n = 1'b1;
   logic                 power_button_n = 1'b1, sleep_request_n = 1'b1;
   logic                 charger_present_n = 1'b1, charger_autoon_en = 1'b0;
   logic                 primary_chip_reset_n = 1'b1;
   logic                 shutdown_req = 1'b0, sleep_enter_req = 1'b0;
   logic                 pwm_enable = 1'b0;
   logic [7:0]           pwm_divider = 8'h00, pwm_duty = 8'h00;
   mps_pkg::mps_wake_s   wake_events = 5'h00;
   logic                 input_power_bad_n, sys_reset_in_n, cpu_reset_in_n;
   logic                 sys_reset_out_n, sys_reset_oe, cpu_reset_out_n, cpu_reset_oe;
   logic                 module_power_en, carrier_power_enable, standby_indication_n;
   logic                 ext_power_req, domain_hold, rtc_wake, fan_pwm;
   mps_pkg::mps_resets_s resets;
   mps_pkg::mps_state_e  state;
   int                   fail_count = 0, check_count = 0, cyc = 0;
   always #20 core_clk = ~core_clk;
   mps_carrier_model i_carrier (.core_clk(core_clk), .vin_ok(vin_ok),
      .sys_pull_n(sys_pull_n), .cpu_pull_n(cpu_pull_n), .sys_reset_out_n(sys_reset_out_n),
      .sys_reset_oe(sys_reset_oe), .cpu_reset_out_n(cpu_reset_out_n),
      .cpu_reset_oe(cpu_reset_oe), .input_power_bad_n(input_power_bad_n),
      .sys_reset_in_n(sys_reset_in_n), .cpu_reset_in_n(cpu_reset_in_n));
   mps_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .input_power_bad_n(input_power_bad_n),
      .power_button_n(power_button_n), .sleep_request_n(sleep_request_n),
      .charger_present_n(charger_present_n), .charger_autoon_en(charger_autoon_en),
      .primary_chip_reset_n(primary_chip_reset_n), .sys_reset_in_n(sys_reset_in_n),
      .sys_reset_out_n(sys_reset_out_n), .sys_reset_oe(sys_reset_oe),
      .cpu_reset_in_n(cpu_reset_in_n), .cpu_reset_out_n(cpu_reset_out_n),
      .cpu_reset_oe(cpu_reset_oe), .shutdown_req(shutdown_req),
      .sleep_enter_req(sleep_enter_req), .wake_events(wake_events),
      .module_power_en(module_power_en), .carrier_power_enable(carrier_power_enable),
      .standby_indication_n(standby_indication_n), .ext_power_req(ext_power_req),
      .domain_hold(domain_hold), .resets(resets), .rtc_wake(rtc_wake),
      .pwm_enable(pwm_enable), .pwm_divider(pwm_divider), .pwm_duty(pwm_duty),
      .fan_pwm(fan_pwm), .state(state));
   // ************************************************************
   // shared helpers
   // ************************************************************
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // waits for a state and checks the wait lies within lo..hi cycles
   task automatic wait_state(input mps_pkg::mps_state_e s, input int lo, input int hi);
      int n;
      n = 0;
      while (state !== s && n <= hi) begin
         step(1);
         n++;
      end
      check({8'h00, (n >= lo && n <= hi)}, 9'h001, "state wait");
   endtask
   task automatic press();
      power_button_n = 1'b0;
      step(4);
      power_button_n = 1'b1;
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      step(3);
      rst_n = 1'b1;
      step(3);
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_refuse();
      check({8'h00, carrier_power_enable}, 9'h000, "carrier en at reset");
      check({8'h00, cpu_reset_oe}, 9'h001, "cpu reset held");
      press();
      step(10);
      check({6'h00, state}, {6'h00, mps_pkg::MPS_OFF}, "power-up while power bad");
   endtask
   task automatic t_power_up(input logic by_button);
      vin_ok = 1'b1;
      step(30);
      if (by_button) press();
      else charger_present_n = 1'b0;
      wait_state(mps_pkg::MPS_MOD_UP, 1, 8);
      step(2);
      check({7'h00, module_power_en, carrier_power_enable}, 9'h002, "own ramp");
      wait_state(mps_pkg::MPS_CAR_UP, 2490, 2510);
      step(1);
      check({7'h00, carrier_power_enable, cpu_reset_oe}, 9'h003, "carrier up");
      wait_state(mps_pkg::MPS_ON, 2490, 2510);
      step(1);
      check({7'h00, cpu_reset_oe, cpu_reset_out_n}, 9'h001, "cpu released");
      check({8'h00, standby_indication_n}, 9'h001, "standby in on");
      charger_present_n = 1'b1;
   endtask
   task automatic t_sleep();
      cpu_pull_n = 1'b0;
      step(8);
      check({8'h00, resets.blocks_rst_n}, 9'h000, "cpu pull resets blocks");
      cpu_pull_n = 1'b1;
      check({6'h00, state}, {6'h00, mps_pkg::MPS_ON}, "cpu pull keeps on");
      sleep_enter_req = 1'b1;
      step(1);
      sleep_enter_req = 1'b0;
      wait_state(mps_pkg::MPS_SLEEP, 0, 0);
      step(1);
      check({7'h00, standby_indication_n, domain_hold}, 9'h001, "sleep outputs");
      wake_events = 5'h02;
      wait_state(mps_pkg::MPS_ON, 1, 20);
      check({7'h00, rtc_wake, ext_power_req}, 9'h003, "wake outputs");
      wake_events = 5'h00;
      step(1);
      check({8'h00, standby_indication_n}, 9'h001, "standby after wake");
      // second sleep, left by the carrier's sleep request pin
      sleep_enter_req = 1'b1;
      step(1);
      sleep_enter_req = 1'b0;
      sleep_request_n = 1'b0;
      wait_state(mps_pkg::MPS_ON, 3, 3);
      sleep_request_n = 1'b1;
   endtask
   task automatic t_shutdown(input logic by_pin);
      if (by_pin) sys_pull_n = 1'b0;
      else shutdown_req = 1'b1;
      step(1);
      shutdown_req = 1'b0;
      wait_state(mps_pkg::MPS_RST_DN, 0, 6);
      sys_pull_n = 1'b1;
      step(1);
      check({7'h00, cpu_reset_oe, carrier_power_enable}, 9'h003, "reset first");
      wait_state(mps_pkg::MPS_CAR_DN, 490, 505);
      step(1);
      check({7'h00, module_power_en, carrier_power_enable}, 9'h002, "carrier off first");
      wait_state(mps_pkg::MPS_OFF, 2490, 2510);
      step(1);
      check({8'h00, module_power_en}, 9'h000, "own power off");
   endtask
   task automatic t_prim_reset();
      primary_chip_reset_n = 1'b0;
      step(8);
      check({5'h00, resets}, 9'h000, "derived resets low");
      primary_chip_reset_n = 1'b1;
      step(8);
      check({8'h00, resets.pmgr_rst_n}, 9'h001, "controller reset released");
   endtask
   task automatic t_pwm();
      int hi;
      hi = 0;
      pwm_enable = 1'b1;
      pwm_duty = 8'h40;
      step(600);
      repeat (256) begin
         step(1);
         hi += (fan_pwm === 1'b1);
      end
      check(9'(hi), 9'h040, "pwm duty n/256");
      // divide by two doubles the period, duty share stays the same
      pwm_divider = 8'h01;
      hi = 0;
      step(600);
      repeat (512) begin
         step(1);
         hi += (fan_pwm === 1'b1);
      end
      check(9'(hi), 9'h080, "pwm divided duty");
      pwm_enable = 1'b0;
   endtask
   // ************************************************************
   // main sequence and hang guard
   // ************************************************************
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         conclude();
      end
   end
   initial begin
      do_reset();
      t_refuse();
      t_power_up(1'b1);
      t_sleep();
      t_shutdown(1'b0);
      charger_autoon_en = 1'b1;
      t_power_up(1'b0);
      t_shutdown(1'b1);
      t_prim_reset();
      t_pwm();
      conclude();
   end
endmodule
`default_nettype wire
